// >>> src/clkbuf_pkg.sv
package clkbuf_pkg;
	// system clock
	localparam int CLK_PERIOD_NS = 50;
	// power-up delay, least figure, rounded up to whole cycles
	localparam real STARTUP_DELAY_MS = 0.1;
	localparam int STARTUP_DELAY_CYC = int'($ceil(STARTUP_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int DELAY_CNT_W = 12;
	// host bit time (100 kHz) split into four quarters
	localparam int SMB_BIT_NS = 10000;
	localparam int SMB_QUARTER_CYC = SMB_BIT_NS / 4 / CLK_PERIOD_NS;
	localparam int QUARTER_CNT_W = 8;
	// target register index map
	localparam logic [7:0] REG_PLL = 8'h00;
	localparam logic [7:0] REG_EN_LO = 8'h01;
	localparam logic [7:0] REG_EN_HI = 8'h02;
	localparam logic [7:0] REG_COUNT = 8'h07;
	// reset values and writable masks
	localparam logic [1:0] SW_MODE_RST = 2'h3;
	localparam logic [7:0] EN_LO_RST = 8'hf7;
	localparam logic [7:0] EN_LO_MASK = 8'hf6;
	localparam logic [7:0] EN_HI_RST = 8'h05;
	localparam logic [7:0] EN_HI_MASK = 8'h05;
	localparam logic [4:0] BYTE_COUNT_RST = 5'h09;
	// byte 0 field positions
	localparam int PLL_SW_SEL_BIT = 3;
	localparam int PLL_SW_MODE_LSB = 1;
	// positions inside the device synchroniser vector
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_COMP = 2;
	localparam int SY_PG = 3;
	localparam int SY_SUP = 4;
	localparam int SY_REF = 5;
	localparam int SY_LOCK = 6;
	localparam int SY_FREQ = 7;
	localparam int SY_BW = 8;
	localparam int SY_OE = 10;
	localparam int SY_W = 18;
	// host register map
	localparam logic [7:0] H_CTRL = 8'h00;
	localparam logic [7:0] H_INDEX = 8'h01;
	localparam logic [7:0] H_COUNT = 8'h02;
	localparam logic [7:0] H_RXCOUNT = 8'h03;
	localparam logic [7:0] H_DATA = 8'h10;
	// tri-level strap codes from the pin detector
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_MID = 2'h1;
	// power-up sequencer states
	typedef enum logic [3:0] {
		P_OFF = 4'b0001,
		P_DELAY = 4'b0010,
		P_WAIT = 4'b0100,
		P_RUN = 4'b1000
	} power_state_t;
	// target byte phases
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_ADDR = 6'b000010,
		S_INDEX = 6'b000100,
		S_COUNT = 6'b001000,
		S_WDATA = 6'b010000,
		S_RDATA = 6'b100000
	} smb_phase_t;
	// host engine states
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_XFER = 4'b0100,
		H_STOP = 4'b1000
	} host_state_t;
endpackage : clkbuf_pkg

// >>> src/smbus_link_if.sv
interface smbus_link_if;
	// host drives clock and data, device drives data only
	logic hostSclOut;
	logic hostSclOe;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	// resolved open-drain wire levels
	logic sclLine;
	logic sdaLine;
	assign sclLine = !(hostSclOe && !hostSclOut);
	assign sdaLine = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));
	modport device (input sclLine, input sdaLine, output devSdaOut, output devSdaOe);
	modport host (input sclLine, input sdaLine, output hostSclOut, output hostSclOe,
		output hostSdaOut, output hostSdaOe);
endinterface : smbus_link_if

// >>> src/sync_edge.sv
module sync_edge #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// foreign levels
	input wire logic [W-1:0] asyncIn,
	// synchronised level and its edges
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta; // first stage, read by second stage only
	logic [W-1:0] prev; // delayed copy for edge finding

	if (W < 1)
	begin : bad_width
		$error("sync_edge needs at least one bit");
	end

	// two-stage synchroniser plus history
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta <= '0;
			level <= '0;
			prev <= '0;
		end
		else if (clkEn)
		begin
			meta <= asyncIn;
			level <= meta;
			prev <= level;
		end
	end

	assign rise = level & ~prev;
	assign fall = ~level & prev;
endmodule : sync_edge

// >>> src/clkbuf_device.sv
// Function
// - supply valid starts the startup delay
// - wait for input clock and power-good
// - PLL lock enters run, outputs enabled
// - power-on to outputs under 1.8 ms
// - outputs stay off without valid clock
// - system sequences power-good after supply
// - block write: address, index, count, data acked
// - block read: address, index, restart, read address
// - read sends count then indexed bytes
// - host acks bytes, ends with nack, stop
// - byte 0 top bits read strap mode
// - software select bit picks software mode
// - software mode field resets to ones
// - new PLL mode applies after warm reset
// - per-output enable bits, zero forces low
// - output runs when bit set, pin low
// - powerdown seen twice tri-states outputs
// - byte count register, default nine
// - power-good rise captures the straps
//
// The address-and-strobe port was left to the implementer.
module clkbuf_device #(
	parameter logic [6:0] SMBUS_ADDR = 7'h6a,
	parameter logic [1:0] MODE_HBW = 2'h3,
	parameter logic [1:0] MODE_BYPASS = 2'h2,
	parameter logic [1:0] MODE_LBW = 2'h1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// serial link
	smbus_link_if.device link,
	// analog status
	input wire logic supplyValid,
	input wire logic refClockValid,
	input wire logic pllLocked,
	input wire logic diffClockOutComp,
	// board pins
	input wire logic powerGoodPowerdownN,
	input wire logic frequencyStrap,
	input wire logic [1:0] pllBandwidthStrap,
	input wire logic [7:0] outEnableN,
	// control to the output stage
	output clkbuf_pkg::power_state_t powerState,
	output logic [1:0] pllMode,
	output logic [7:0] outputRun,
	output logic outputsHiZ
);
	import clkbuf_pkg::*;

	logic [SY_W-1:0] syLevel; // synchronised inputs
	logic [SY_W-1:0] syRise; // their rising edges
	logic [SY_W-1:0] syFall; // their falling edges
	logic [DELAY_CNT_W-1:0] delayCnt; // startup delay counter
	logic pgoodSeen; // power-good has risen once
	logic [1:0] strapMode; // latched PLL mode
	logic freqLatched; // latched frequency strap
	logic swSelect; // software mode select
	logic [1:0] swMode; // software mode field
	logic [7:0] enLow; // output enable byte 1
	logic [7:0] enHigh; // output enable byte 2
	logic [4:0] byteCount; // read length register
	logic [1:0] pdCount; // powerdown samples on comp rises
	smb_phase_t phase; // target byte phase
	logic [3:0] bitCnt; // bit within byte, 8 is the ack slot, 15 awaits first fall
	logic [7:0] shiftReg; // received byte
	logic [7:0] txByte; // byte being sent
	logic [7:0] index; // register pointer
	logic sendCount; // next read byte is the count
	logic sdaOe; // pull data low
	logic startCond; // start or repeated start
	logic stopCond; // stop
	logic wrHit; // data byte completed in a write
	logic [7:0] readByte; // register read mux
	logic [7:0] txNext; // next byte to send
	logic [7:0] regEnables; // enable bits per output

	if (MODE_HBW == MODE_BYPASS || MODE_HBW == MODE_LBW || MODE_BYPASS == MODE_LBW)
	begin : bad_modes
		$error("PLL mode codes must differ");
	end
	if (SMBUS_ADDR == 7'h00)
	begin : bad_addr
		$error("target address must not be the general call address");
	end

	// every foreign input passes two flops
	sync_edge #(.W(SY_W)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.asyncIn({outEnableN, pllBandwidthStrap, frequencyStrap, pllLocked, refClockValid,
			supplyValid, powerGoodPowerdownN, diffClockOutComp, link.sdaLine, link.sclLine}),
		.level(syLevel),
		.rise(syRise),
		.fall(syFall)
	);

	// tri-level strap to mode code
	function automatic logic [1:0] modeOf(input logic [1:0] level);
		if (level == STRAP_LOW)
			return MODE_LBW;
		else if (level == STRAP_MID)
			return MODE_BYPASS;
		else
			return MODE_HBW;
	endfunction : modeOf

	// power-up sequencer
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			powerState <= P_OFF;
		else if (clkEn)
		begin
			if (!syLevel[SY_SUP])
				powerState <= P_OFF;
			else
			begin
				unique case (powerState)
					P_OFF:
						powerState <= P_DELAY;
					P_DELAY:
						if (delayCnt == DELAY_CNT_W'(STARTUP_DELAY_CYC - 1))
							powerState <= P_WAIT;
					P_WAIT:
						// clock, power-good and lock all needed
						if (syLevel[SY_REF] && syLevel[SY_PG] && syLevel[SY_LOCK])
							powerState <= P_RUN;
					P_RUN:
						// lost clock or lock drops back
						if (!syLevel[SY_REF] || !syLevel[SY_LOCK])
							powerState <= P_WAIT;
				endcase
			end
		end
	end

	// startup delay counter, runs only in the delay state
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			delayCnt <= '0;
		else if (clkEn)
			delayCnt <= (powerState == P_DELAY) ? delayCnt + 1'b1 : '0;
	end

	// strap capture on the first power-good rise
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pgoodSeen <= 1'b0;
			strapMode <= 2'h0;
			freqLatched <= 1'b0;
		end
		else if (clkEn)
		begin
			if (!syLevel[SY_SUP])
				pgoodSeen <= 1'b0; // power lost, next rise samples again
			else if (syRise[SY_PG] && !pgoodSeen)
			begin
				pgoodSeen <= 1'b1;
				strapMode <= modeOf(syLevel[SY_BW +: 2]);
				freqLatched <= syLevel[SY_FREQ];
			end
		end
	end

	// mode handed to the PLL, fixed while in run
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pllMode <= MODE_HBW;
		else if (clkEn && powerState != P_RUN)
			pllMode <= swSelect ? swMode : strapMode;
	end

	// powerdown: two low samples on comp rises, then off at a comp fall
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pdCount <= 2'h0;
			outputsHiZ <= 1'b1;
		end
		else if (clkEn)
		begin
			if (syRise[SY_COMP])
				pdCount <= syLevel[SY_PG] ? 2'h0 : (pdCount == 2'h2 ? 2'h2 : pdCount + 2'h1);
			if (!pgoodSeen)
				outputsHiZ <= 1'b1; // before first power-good
			else if (syFall[SY_COMP] && pdCount == 2'h2)
				outputsHiZ <= 1'b1;
			else if (syLevel[SY_PG] && (syFall[SY_COMP] || powerState != P_RUN))
				outputsHiZ <= 1'b0;
		end
	end

	assign regEnables = {enHigh[2], enHigh[0], enLow[7:4], enLow[2:1]};

	// output gates load only while the comp output is falling, clear at once
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			outputRun <= 8'h00;
		else if (clkEn)
		begin
			// same terms that drop the sequencer out of run, plus tri-state, so both move together
			if (powerState != P_RUN || outputsHiZ || !syLevel[SY_SUP] || !syLevel[SY_REF]
				|| !syLevel[SY_LOCK])
				outputRun <= 8'h00;
			else if (syFall[SY_COMP])
				outputRun <= regEnables & ~syLevel[SY_OE +: 8];
		end
	end

	// bus conditions seen while the clock line is high
	assign startCond = syFall[SY_SDA] && syLevel[SY_SCL] && !syFall[SY_SCL];
	assign stopCond = syRise[SY_SDA] && syLevel[SY_SCL] && !syFall[SY_SCL];
	assign wrHit = syFall[SY_SCL] && bitCnt == 4'h7 && phase == S_WDATA && !startCond && !stopCond;

	// register read mux
	always_comb
	begin
		readByte = 8'h00;
		case (index)
			REG_PLL:
				readByte = {strapMode, 2'b00, swSelect, swMode, freqLatched};
			REG_EN_LO:
				readByte = enLow;
			REG_EN_HI:
				readByte = enHigh;
			REG_COUNT:
				readByte = {3'b000, byteCount};
			default:
				readByte = 8'h00; // unused indices read zero
		endcase
		txNext = sendCount ? {3'b000, byteCount} : readByte;
	end

	// register writes from completed data bytes
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			swSelect <= 1'b0;
			swMode <= SW_MODE_RST;
			enLow <= EN_LO_RST;
			enHigh <= EN_HI_RST;
			byteCount <= BYTE_COUNT_RST;
		end
		else if (clkEn && wrHit)
		begin
			case (index)
				REG_PLL:
				begin
					swSelect <= shiftReg[PLL_SW_SEL_BIT];
					swMode <= shiftReg[PLL_SW_MODE_LSB +: 2];
				end
				REG_EN_LO:
					enLow <= (shiftReg & EN_LO_MASK) | (EN_LO_RST & ~EN_LO_MASK);
				REG_EN_HI:
					enHigh <= (shiftReg & EN_HI_MASK) | (EN_HI_RST & ~EN_HI_MASK);
				REG_COUNT:
					byteCount <= shiftReg[4:0];
				default:
					byteCount <= byteCount; // read-only or unused index
			endcase
		end
	end

	// serial target engine
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			phase <= S_IDLE;
			bitCnt <= 4'h0;
			shiftReg <= 8'h00;
			txByte <= 8'h00;
			index <= 8'h00;
			sendCount <= 1'b0;
			sdaOe <= 1'b0;
		end
		else if (clkEn)
		begin
			if (startCond)
			begin
				phase <= S_ADDR; // index survives a repeated start
				bitCnt <= 4'hf; // clock fall that closes the start is not a bit
				sdaOe <= 1'b0;
			end
			else if (stopCond)
			begin
				phase <= S_IDLE;
				sdaOe <= 1'b0;
			end
			else if (phase != S_IDLE)
			begin
				if (syRise[SY_SCL] && bitCnt != 4'h8)
					shiftReg <= {shiftReg[6:0], syLevel[SY_SDA]};
				// host nack ends a read
				if (syRise[SY_SCL] && bitCnt == 4'h8 && phase == S_RDATA && syLevel[SY_SDA])
					phase <= S_IDLE;
				if (syFall[SY_SCL])
				begin
					if (bitCnt == 4'h7)
					begin
						bitCnt <= 4'h8;
						unique case (phase)
							S_ADDR:
								if (shiftReg[7:1] == SMBUS_ADDR)
								begin
									sdaOe <= 1'b1;
									phase <= shiftReg[0] ? S_RDATA : S_INDEX;
									sendCount <= shiftReg[0];
								end
								else
									phase <= S_IDLE;
							S_INDEX:
							begin
								index <= shiftReg;
								sdaOe <= 1'b1;
								phase <= S_COUNT;
							end
							S_COUNT:
							begin
								sdaOe <= 1'b1;
								phase <= S_WDATA;
							end
							S_WDATA:
							begin
								sdaOe <= 1'b1;
								index <= index + 8'h01;
							end
							S_RDATA:
								sdaOe <= 1'b0; // host answers here
							S_IDLE:
								sdaOe <= 1'b0;
						endcase
					end
					else if (bitCnt == 4'h8)
					begin
						bitCnt <= 4'h0;
						if (phase == S_RDATA)
						begin
							txByte <= txNext;
							sdaOe <= !txNext[7];
							sendCount <= 1'b0;
							if (!sendCount)
								index <= index + 8'h01;
						end
						else
							sdaOe <= 1'b0;
					end
					else
					begin
						bitCnt <= bitCnt + 4'h1;
						if (phase == S_RDATA)
							sdaOe <= !txByte[3'(3'd6 - bitCnt[2:0])];
					end
				end
			end
		end
	end

	assign link.devSdaOe = sdaOe;
	assign link.devSdaOut = 1'b0;
endmodule : clkbuf_device

// >>> src/smbus_host.sv
module smbus_host #(
	parameter logic [6:0] TARGET_ADDR = 7'h6a,
	parameter int DATA_DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// serial link
	smbus_link_if.host link,
	// software register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	// board power sequencing
	input wire logic supplyOk,
	output logic powerGood,
	output clkbuf_pkg::host_state_t hostState
);
	import clkbuf_pkg::*;

	logic [1:0] syLevel; // synchronised data line and supply
	logic [QUARTER_CNT_W-1:0] qCnt; // quarter bit timer
	logic tick; // quarter boundary
	logic [1:0] qPhase; // quarter within bit
	logic [3:0] bitIdx; // bit within byte, 8 is ack
	logic [4:0] step; // byte number in transfer
	logic [7:0] txByte; // byte to send
	logic [7:0] rxByte; // byte received
	logic [7:0] index; // target start index
	logic [3:0] count; // data bytes to move
	logic [7:0] rxCount; // count byte returned by target
	logic rdOp; // transfer is a read
	logic busy; // transfer running
	logic nackErr; // target failed to ack
	logic pgReq; // software wants power-good
	logic sclOe; // pull clock low
	logic sdaOe; // pull data low
	logic receiving; // current byte comes from target
	logic [4:0] lastStep; // final byte of transfer
	logic storeRx; // received data byte complete
	logic [7:0] buffer [DATA_DEPTH]; // data bytes

	if (DATA_DEPTH < 1 || DATA_DEPTH > 8 || SMB_QUARTER_CYC < 2)
	begin : bad_cfg
		$error("unsupported host configuration");
	end

	sync_edge #(.W(2)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.asyncIn({supplyOk, link.sdaLine}),
		.level(syLevel),
		.rise(),
		.fall()
	);

	assign tick = (qCnt == QUARTER_CNT_W'(SMB_QUARTER_CYC - 1));
	assign receiving = rdOp && step >= 5'd3;
	assign lastStep = rdOp ? 5'd3 + 5'(count) : 5'd2 + 5'(count);
	assign storeRx = tick && hostState == H_XFER && qPhase == 2'h3 && bitIdx == 4'h8
		&& receiving && step >= 5'd4;

	// byte sent at each step
	always_comb
	begin
		unique case (step)
			5'd0:
				txByte = {TARGET_ADDR, 1'b0};
			5'd1:
				txByte = index;
			5'd2:
				txByte = rdOp ? {TARGET_ADDR, 1'b1} : {4'h0, count};
			default:
				txByte = buffer[3'(step - 5'd3)];
		endcase
	end

	// power-good follows software only while supply is valid
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			powerGood <= 1'b0;
		else if (clkEn)
			powerGood <= pgReq && syLevel[1];
	end

	// quarter timer
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			qCnt <= '0;
		else if (clkEn)
			qCnt <= (hostState == H_IDLE || tick) ? '0 : qCnt + 1'b1;
	end

	// data buffer, written by software or by received bytes
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < DATA_DEPTH; i++)
				buffer[i] <= 8'h00;
		end
		else if (clkEn)
		begin
			if (storeRx)
				buffer[3'(step - 5'd4)] <= rxByte;
			else if (regWrite && regAddr >= H_DATA && regAddr < H_DATA + 8'(DATA_DEPTH))
				buffer[3'(regAddr - H_DATA)] <= regWdata;
		end
	end

	// register read port, data one cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			regRdata <= 8'h00;
		else if (clkEn && regRead)
		begin
			if (regAddr == H_CTRL)
				regRdata <= {4'h0, nackErr, pgReq, rdOp, busy};
			else if (regAddr == H_INDEX)
				regRdata <= index;
			else if (regAddr == H_COUNT)
				regRdata <= {4'h0, count};
			else if (regAddr == H_RXCOUNT)
				regRdata <= rxCount;
			else if (regAddr >= H_DATA && regAddr < H_DATA + 8'(DATA_DEPTH))
				regRdata <= buffer[3'(regAddr - H_DATA)];
			else
				regRdata <= 8'h00;
		end
	end

	// settings and transfer engine
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hostState <= H_IDLE;
			qPhase <= 2'h0;
			bitIdx <= 4'h0;
			step <= 5'd0;
			rxByte <= 8'h00;
			index <= 8'h00;
			count <= 4'h0;
			rxCount <= 8'h00;
			rdOp <= 1'b0;
			busy <= 1'b0;
			nackErr <= 1'b0;
			pgReq <= 1'b0;
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
		end
		else if (clkEn)
		begin
			if (regWrite && regAddr == H_CTRL)
				pgReq <= regWdata[2];
			if (regWrite && regAddr == H_INDEX && !busy)
				index <= regWdata;
			if (regWrite && regAddr == H_COUNT && !busy)
				count <= (regWdata[3:0] > 4'(DATA_DEPTH)) ? 4'(DATA_DEPTH) : regWdata[3:0];
			unique case (hostState)
				H_IDLE:
					if (regWrite && regAddr == H_CTRL && regWdata[0])
					begin
						rdOp <= regWdata[1];
						busy <= 1'b1;
						nackErr <= 1'b0;
						step <= 5'd0;
						qPhase <= 2'h0;
						hostState <= H_START;
					end
				H_START:
					if (tick)
					begin
						qPhase <= qPhase + 2'h1;
						if (qPhase == 2'h0)
							sdaOe <= 1'b0;
						else if (qPhase == 2'h1)
							sclOe <= 1'b0;
						else if (qPhase == 2'h2)
							sdaOe <= 1'b1; // start while clock high
						else
						begin
							sclOe <= 1'b1;
							bitIdx <= 4'h0;
							hostState <= H_XFER;
						end
					end
				H_XFER:
					if (tick)
					begin
						qPhase <= qPhase + 2'h1;
						if (qPhase == 2'h0)
						begin
							if (bitIdx != 4'h8)
								sdaOe <= receiving ? 1'b0 : !txByte[3'(3'd7 - bitIdx[2:0])];
							else
								sdaOe <= receiving && step != lastStep;
						end
						else if (qPhase == 2'h1)
							sclOe <= 1'b0;
						else if (qPhase == 2'h2)
						begin
							if (bitIdx != 4'h8)
								rxByte <= {rxByte[6:0], syLevel[0]};
							else if (!receiving && syLevel[0])
								nackErr <= 1'b1;
						end
						else
						begin
							sclOe <= 1'b1;
							if (bitIdx != 4'h8)
								bitIdx <= bitIdx + 4'h1;
							else
							begin
								bitIdx <= 4'h0;
								if (receiving && step == 5'd3)
									rxCount <= rxByte;
								if (nackErr || step == lastStep)
									hostState <= H_STOP;
								else if (rdOp && step == 5'd1)
								begin
									step <= 5'd2;
									hostState <= H_START;
								end
								else
									step <= step + 5'd1;
							end
						end
					end
				H_STOP:
					if (tick)
					begin
						qPhase <= qPhase + 2'h1;
						if (qPhase == 2'h0)
							sdaOe <= 1'b1;
						else if (qPhase == 2'h1)
							sclOe <= 1'b0;
						else if (qPhase == 2'h2)
							sdaOe <= 1'b0; // stop while clock high
						else
						begin
							busy <= 1'b0;
							hostState <= H_IDLE;
						end
					end
			endcase
		end
	end

	assign link.hostSclOe = sclOe;
	assign link.hostSdaOe = sdaOe;
	assign link.hostSclOut = 1'b0;
	assign link.hostSdaOut = 1'b0;
endmodule : smbus_host

// >>> verification/clkbuf_chk.sv
module clkbuf_chk (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link wires
	input wire logic sclLine,
	input wire logic hostSdaOe,
	input wire logic devSdaOe,
	// sequencer view
	input wire logic refClockValid,
	input wire logic powerGoodPowerdownN,
	input wire clkbuf_pkg::power_state_t powerState,
	input wire logic [7:0] outputRun,
	input wire logic outputsHiZ
);
	timeunit 1ns;
	timeprecision 1ns;
	import clkbuf_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// cycles spent in the startup delay
	logic [12:0] delayCnt;
	// counts while delaying, clears elsewhere
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			delayCnt <= 13'h0;
		else if (powerState == P_DELAY)
			delayCnt <= delayCnt + 13'h1;
		else
			delayCnt <= 13'h0;
	end
	// delay over, now waiting for clock and power-good
	sequence s_delayDone;
		$past(powerState) == P_DELAY && powerState == P_WAIT;
	endsequence
	// wait over, now running
	sequence s_runEntry;
		$past(powerState) == P_WAIT && powerState == P_RUN;
	endsequence
	a_delay_length:
	assert property (s_delayDone |-> delayCnt >= STARTUP_DELAY_CYC - 1 && delayCnt <= 13'h1770)
		else $error("startup delay out of range");
	a_state_onehot:
	assert property ($onehot(powerState)) else $error("sequencer state not one-hot");
	a_run_only_run:
	assert property (outputRun != 8'h00 |-> powerState == P_RUN)
		else $error("output running outside run state");
	a_run_entry_ok:
	assert property (s_runEntry |-> refClockValid && powerGoodPowerdownN)
		else $error("run entered without clock or power-good");
	a_no_clock_hold:
	assert property (powerState == P_WAIT && !refClockValid && !$past(refClockValid, 4)
		|=> powerState != P_RUN) else $error("run entered without input clock");
	a_dev_scl_low:
	assert property ($changed(devSdaOe) |-> !sclLine) else $error("device moved data with clock high");
	a_no_fight:
	assert property (sclLine && devSdaOe |-> !hostSdaOe) else $error("both ends drive data");
	a_hiz_cause:
	assert property ($rose(outputsHiZ) |-> !powerGoodPowerdownN && !$past(powerGoodPowerdownN, 8))
		else $error("tri-state without powerdown");
endmodule : clkbuf_chk

// >>> verification/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import clkbuf_pkg::*;
	// clock, reset, board levels
	logic clk, sys_rst, supply, refOk, locked, pdN, hostPg, pgPin, regWrite, regRead, outputsHiZ;
	logic [7:0] oeN, regAddr, regWdata, regRdata, outputRun;
	logic [1:0] pllMode; // mode handed to the PLL
	logic [2:0] ph = 3'h0;
	power_state_t powerState;
	int badCount = 0, checksDone = 0, cyc = 0;
	smbus_link_if link();
	assign pgPin = hostPg & pdN;
	// system clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// complementary output clock and cycle count
	always @(posedge clk)
	begin
		ph <= ph + 3'h1;
		cyc <= cyc + 1;
	end
	clkbuf_device clkbuf_device_i (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .link(link.device),
		.supplyValid(supply), .refClockValid(refOk), .pllLocked(locked), .diffClockOutComp(ph[2]),
		.powerGoodPowerdownN(pgPin), .frequencyStrap(1'b1), .pllBandwidthStrap(STRAP_MID),
		.outEnableN(oeN), .powerState(powerState), .pllMode(pllMode), .outputRun(outputRun),
		.outputsHiZ(outputsHiZ));
	smbus_host smbus_host_i (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .link(link.host),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .supplyOk(supply), .powerGood(hostPg), .hostState());
	clkbuf_chk clkbuf_chk_i (.clk(clk), .sys_rst(sys_rst), .sclLine(link.sclLine),
		.hostSdaOe(link.hostSdaOe), .devSdaOe(link.devSdaOe), .refClockValid(refOk),
		.powerGoodPowerdownN(pgPin), .powerState(powerState), .outputRun(outputRun),
		.outputsHiZ(outputsHiZ));
	task automatic printVerdict();
		if (badCount == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : printVerdict
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			badCount++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	// one-cycle read, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
		d = regRdata;
	endtask : rd
	// start a transfer, poll busy, expect no nack
	task automatic xfer(input logic [7:0] ctl);
		logic [7:0] s;
		wr(H_CTRL, ctl);
		s = 8'h01;
		for (int i = 0; i < 400 && s[0] !== 1'b0; i++)
		begin
			repeat (100) @(posedge clk);
			rd(H_CTRL, s);
		end
		cmp(s, ctl & 8'h06);
		if (s[0] !== 1'b0)
			printVerdict();
	endtask : xfer
	task automatic waitState(input power_state_t st);
		for (int i = 0; i < 40000 && powerState !== st; i++)
			@(posedge clk);
		cmp({4'h0, powerState}, {4'h0, st});
		if (powerState !== st)
			printVerdict();
	endtask : waitState
	task automatic waitRun(input logic [7:0] e);
		for (int i = 0; i < 100 && outputRun !== e; i++)
			@(posedge clk);
		cmp(outputRun, e);
	endtask : waitRun
	// supply, delay, lock without clock held off, then clock
	task automatic powerUp();
		int t0;
		supply <= 1'b1;
		t0 = cyc;
		wr(H_CTRL, 8'h04);
		waitState(P_WAIT);
		cmp(8'(cyc - t0 >= STARTUP_DELAY_CYC), 8'h01);
		locked <= 1'b1;
		repeat (200) @(posedge clk);
		cmp({4'h0, powerState} | outputRun, {4'h0, P_WAIT});
		refOk <= 1'b1;
		waitState(P_RUN);
		cmp(8'(cyc - t0 < 36000), 8'h01);
		waitRun(8'hff);
	endtask : powerUp
	// write bytes 0..2, then a pin disables one output
	task automatic blockWrite();
		wr(H_INDEX, 8'h00);
		wr(H_COUNT, 8'h03);
		wr(H_DATA, 8'hff);
		wr(H_DATA + 8'h01, 8'h20);
		wr(H_DATA + 8'h02, 8'h01);
		xfer(8'h05);
		waitRun(8'h48);
		oeN <= 8'h08;
		waitRun(8'h40);
	endtask : blockWrite
	// read bytes 0..2 back with the count byte first
	task automatic blockRead();
		logic [7:0] d;
		logic [7:0] exp [3] = '{8'h8f, 8'h21, 8'h01};
		xfer(8'h07);
		rd(H_RXCOUNT, d);
		cmp(d, 8'h09);
		for (int i = 0; i < 3; i++)
		begin
			rd(H_DATA + 8'(i), d);
			cmp(d, exp[i]);
		end
	endtask : blockRead
	// software mode reaches the PLL once lost lock drops the sequencer out of run
	task automatic warmRestart();
		cmp({6'h00, pllMode}, 8'h02);
		locked <= 1'b0;
		waitState(P_WAIT);
		repeat (2) @(posedge clk);
		cmp(outputRun, 8'h00);
		cmp({6'h00, pllMode}, 8'h03);
		locked <= 1'b1;
		waitState(P_RUN);
		cmp({6'h00, pllMode}, 8'h03);
		waitRun(8'h40);
	endtask : warmRestart
	task automatic powerDown();
		pdN <= 1'b0;
		for (int i = 0; i < 100 && outputsHiZ !== 1'b1; i++)
			@(posedge clk);
		cmp({7'h0, outputsHiZ}, 8'h01);
	endtask : powerDown
	// main sequence
	initial
	begin
		sys_rst = 1'b1;
		supply = 1'b0;
		refOk = 1'b0;
		locked = 1'b0;
		pdN = 1'b1;
		oeN = 8'h00;
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		powerUp();
		blockWrite();
		blockRead();
		warmRestart();
		powerDown();
		printVerdict();
	end
endmodule : tb
